// ---- pdsr_defines.svh ----
// Register offsets, field positions, reset values and timing counts of the PHY diag/status register group.
// Assumes byte addresses on a 32-bit Avalon-MM bus, one aligned word per register.
`ifndef PDSR_DEFINES_SVH
`define PDSR_DEFINES_SVH

// Printed offsets are not all multiples of four: they are indices, byte address = 4 * index
`define PDSR_IDX_LOOPBACK    12'h122
`define PDSR_IDX_DIAG        12'h124
`define PDSR_IDX_LINK        12'h126
`define PDSR_IDX_SYMERR      12'h12A
`define PDSR_IDX_IRQ_STATUS  12'h140
`define PDSR_IDX_IRQ_MASK    12'h141
`define PDSR_ADDR_W          14

`define PDSR_LOOPBACK_BIT    8
`define PDSR_LOOPBACK_RSV_HI 15
`define PDSR_LOOPBACK_RSV_LO 9
`define PDSR_LOOPBACK_RST    16'h00F4
`define PDSR_LOOPBACK_WMASK  16'hFFFC

`define PDSR_DIAG_EN_BIT     15
`define PDSR_DIAG_RSV14_BIT  14
`define PDSR_DIAG_PAIR_HI    13
`define PDSR_DIAG_PAIR_LO    12
`define PDSR_DIAG_RSV_HI     11
`define PDSR_DIAG_RSV_LO     10
`define PDSR_DIAG_RES_HI     9
`define PDSR_DIAG_RES_LO     8

`define PDSR_LINK_GIG_BIT    1
`define PDSR_LINK_FAST_BIT   0

`define PDSR_SYMERR_MAX      16'hFFFF

`define PDSR_IRQ_DONE_BIT    0
`define PDSR_IRQ_SATUR_BIT   1
`define PDSR_IRQ_LINK_BIT    2
`define PDSR_IRQ_W           3

// Cable test duration
`define PDSR_CLK_HZ          25000000
`define PDSR_DIAG_TIME_US    20
`define PDSR_DIAG_CYCLES     ((`PDSR_DIAG_TIME_US * `PDSR_CLK_HZ + 999999) / 1000000)

`endif

// ---- pdsr_pkg.sv ----
// Types shared by the PHY diag/status register group.
// Assumes nothing of its surroundings.
`default_nettype none
package pdsr_pkg;
  typedef enum logic [1:0] {
    PDSR_PAIR_A = 2'h0,
    PDSR_PAIR_B = 2'h1,
    PDSR_PAIR_C = 2'h2,
    PDSR_PAIR_D = 2'h3
  } pdsr_pair_type;

  typedef enum logic [1:0] {
    PDSR_CABLE_NORMAL = 2'h0,
    PDSR_CABLE_OPEN   = 2'h1,
    PDSR_CABLE_SHORT  = 2'h2,
    PDSR_CABLE_RSV    = 2'h3
  } pdsr_cable_type;

  typedef enum logic [1:0] {
    PDSR_DG_IDLE = 2'h0,
    PDSR_DG_RUN  = 2'h1,
    PDSR_DG_DONE = 2'h2
  } pdsr_diag_state_type;
endpackage
`default_nettype wire

// ---- pdsr_regs.sv ----
// Per-port PHY loopback, cable diagnostic, link status and symbol-error count registers.
// Assumes an Avalon-MM master on ref_clk_i, datapath inputs on the same clock, link and
// cable result inputs from the analog side arriving asynchronously.
`timescale 1ns/10ps
`default_nettype none
`include "pdsr_defines.svh"

// What this block does
// RULE1 - Loopback bit 8 returns line traffic
// RULE2 - PHY port: line receive to line transmit
// RULE3 - MAC port: transmit pins to receive pins
// RULE4 - Enable bit 15 starts test, self-clears
// RULE5 - Writing zero stops the cable test
// RULE6 - Enable reads one while test runs
// RULE7 - Bits 13:12 select pair A to D
// RULE8 - Result 9:8: normal, open, short
// RULE9 - Sixteen-bit count of symbol-error frames
// RULE10 - Counter clears on read, saturates
module pdsr_regs
  import pdsr_pkg::*;
#(
  parameter int DIAG_CYCLES = `PDSR_DIAG_CYCLES
) (
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    rstn_i,
  // Avalon-MM slave
  input  wire logic [`PDSR_ADDR_W-1:0] avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output var  logic [31:0]             avs_readdata_o,
  output var  logic                    avs_waitrequest_o,
  output var  logic [1:0]              avs_response_o,
  // Copper line datapath
  input  wire logic [7:0]              line_rx_data_i,
  input  wire logic                    line_rx_valid_i,
  input  wire logic [7:0]              fabric_tx_data_i,
  input  wire logic                    fabric_tx_valid_i,
  output var  logic [7:0]              line_tx_data_o,
  output var  logic                    line_tx_valid_o,
  output var  logic [7:0]              fabric_rx_data_o,
  output var  logic                    fabric_rx_valid_o,
  // External MAC port interface datapath
  input  wire logic [7:0]              mac_txd_i,
  input  wire logic                    mac_tx_en_i,
  input  wire logic [7:0]              mac_fabric_data_i,
  input  wire logic                    mac_fabric_valid_i,
  output var  logic [7:0]              mac_rxd_o,
  output var  logic                    mac_rx_dv_o,
  output var  logic                    mac_loopback_o,
  // Receive error events
  input  wire logic                    receive_symbol_error_i,
  input  wire logic                    rx_frame_end_i,
  // Analog cable tester and link monitor (inputs asynchronous, outputs registered on ref_clk_i)
  input  wire logic                    cable_done_i,
  input  wire logic [1:0]              cable_result_i,
  input  wire logic                    link_gig_i,
  input  wire logic                    link_fast_i,
  output var  logic                    cable_test_run_o,
  output var  logic [1:0]              cable_pair_o,
  // Interrupt
  output var  logic                    irq_o
);

  localparam logic [31:0] DIAG_CNT = DIAG_CYCLES;

  logic [15:0]               loop_q;
  logic                      diag_en_q;
  logic                      diag_rsv14_q;
  pdsr_pair_type             pair_q;
  logic [1:0]                diag_rsv_q;
  pdsr_cable_type            result_q;
  pdsr_diag_state_type       dg_state_q;
  logic [31:0]               dg_cnt_q;
  logic [15:0]               symerr_q;
  logic                      frame_err_q;
  logic [`PDSR_IRQ_W-1:0]    irq_stat_q;
  logic [`PDSR_IRQ_W-1:0]    irq_mask_q;
  logic                      ack_q;
  logic [3:0]                async_sync;
  logic                      done_sync;
  logic [1:0]                res_sync;
  logic                      gig_sync;
  logic                      fast_sync;
  logic                      gig_prev_q;
  logic                      fast_prev_q;

  // Word index from byte address; low two bits are ignored
  function automatic logic [11:0] word_idx(input logic [`PDSR_ADDR_W-1:0] a);
    return a[`PDSR_ADDR_W-1:2];
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  pdsr_sync3 #(
    .W(4)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .async_i   ({cable_done_i, cable_result_i, link_gig_i}),
    .sync_o    (async_sync)
  );

  pdsr_sync3 #(
    .W(1)
  ) u_sync_fast (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .async_i   (link_fast_i),
    .sync_o    (fast_sync)
  );

  assign done_sync = async_sync[3];
  assign res_sync  = async_sync[2:1];
  assign gig_sync  = async_sync[0];

  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic [11:0] idx;
  logic [15:0] wdiag;
  assign acc    = (avs_read_i || avs_write_i) && !ack_q;
  assign wr_acc = avs_write_i && !ack_q;
  assign rd_acc = avs_read_i && !ack_q;
  assign idx    = word_idx(avs_address_i);
  assign wdiag  = merge16({diag_en_q, diag_rsv14_q, pair_q, diag_rsv_q, result_q, 8'h00},
                          avs_writedata_i, avs_byteenable_i);

  // One wait state: waitrequest drops for one cycle after a request is seen
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_q             <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else begin
      ack_q             <= acc;
      avs_waitrequest_o <= !acc;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'h0;
    end else if (acc) begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'h0;
      if (idx == `PDSR_IDX_LOOPBACK) begin
        avs_readdata_o[15:0] <= loop_q;
      end else if (idx == `PDSR_IDX_DIAG) begin
        avs_readdata_o[15:0] <= {diag_en_q, diag_rsv14_q, pair_q, diag_rsv_q, result_q, 8'h00};
      end else if (idx == `PDSR_IDX_LINK) begin
        avs_readdata_o[15:0] <= {14'h0000, gig_sync, fast_sync};
      end else if (idx == `PDSR_IDX_SYMERR) begin
        avs_readdata_o[15:0] <= symerr_q;
      end else if (idx == `PDSR_IDX_IRQ_STATUS) begin
        avs_readdata_o[`PDSR_IRQ_W-1:0] <= irq_stat_q;
      end else if (idx == `PDSR_IDX_IRQ_MASK) begin
        avs_readdata_o[`PDSR_IRQ_W-1:0] <= irq_mask_q;
      end else begin
        avs_response_o <= 2'h2;
      end
    end
  end

  // RULE1 loopback control storage
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      loop_q <= `PDSR_LOOPBACK_RST;
    end else if (wr_acc && idx == `PDSR_IDX_LOOPBACK) begin
      // Bit 0 is read-only, bit 1 clears on read and is kept at zero here
      loop_q <= merge16(loop_q, avs_writedata_i, avs_byteenable_i) & `PDSR_LOOPBACK_WMASK | 16'h0000;
    end
  end

  // RULE2 line receive looped to line transmit
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_tx_data_o    <= 8'h00;
      line_tx_valid_o   <= 1'b0;
      fabric_rx_data_o  <= 8'h00;
      fabric_rx_valid_o <= 1'b0;
    end else if (loop_q[`PDSR_LOOPBACK_BIT]) begin
      line_tx_data_o    <= line_rx_data_i;
      line_tx_valid_o   <= line_rx_valid_i;
      fabric_rx_data_o  <= 8'h00;
      fabric_rx_valid_o <= 1'b0;
    end else begin
      line_tx_data_o    <= fabric_tx_data_i;
      line_tx_valid_o   <= fabric_tx_valid_i;
      fabric_rx_data_o  <= line_rx_data_i;
      fabric_rx_valid_o <= line_rx_valid_i;
    end
  end

  // RULE3 MAC transmit pins looped to receive pins
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mac_rxd_o      <= 8'h00;
      mac_rx_dv_o    <= 1'b0;
      mac_loopback_o <= 1'b0;
    end else begin
      mac_loopback_o <= loop_q[`PDSR_LOOPBACK_BIT];
      if (loop_q[`PDSR_LOOPBACK_BIT]) begin
        mac_rxd_o   <= mac_txd_i;
        mac_rx_dv_o <= mac_tx_en_i;
      end else begin
        mac_rxd_o   <= mac_fabric_data_i;
        mac_rx_dv_o <= mac_fabric_valid_i;
      end
    end
  end

  // RULE7 pair select and reserved writable bits
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pair_q       <= PDSR_PAIR_A;
      diag_rsv14_q <= 1'b0;
      diag_rsv_q   <= 2'h0;
    end else if (wr_acc && idx == `PDSR_IDX_DIAG) begin
      pair_q       <= pdsr_pair_type'(wdiag[`PDSR_DIAG_PAIR_HI:`PDSR_DIAG_PAIR_LO]);
      diag_rsv14_q <= wdiag[`PDSR_DIAG_RSV14_BIT];
      diag_rsv_q   <= wdiag[`PDSR_DIAG_RSV_HI:`PDSR_DIAG_RSV_LO];
    end
  end

  // RULE4 cable test launch and self-clear
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dg_state_q <= PDSR_DG_IDLE;
      diag_en_q  <= 1'b0;
      dg_cnt_q   <= 32'h0000_0000;
      result_q   <= PDSR_CABLE_NORMAL;
    end else begin
      case (dg_state_q)
        PDSR_DG_IDLE: begin
          if (wr_acc && idx == `PDSR_IDX_DIAG && wdiag[`PDSR_DIAG_EN_BIT]) begin
            dg_state_q <= PDSR_DG_RUN;
            diag_en_q  <= 1'b1;
            dg_cnt_q   <= 32'h0000_0000;
          end
        end
        PDSR_DG_RUN: begin
          dg_cnt_q <= dg_cnt_q + 32'h0000_0001;
          // RULE5 writing zero aborts
          if (wr_acc && idx == `PDSR_IDX_DIAG && !wdiag[`PDSR_DIAG_EN_BIT]) begin
            dg_state_q <= PDSR_DG_IDLE;
            diag_en_q  <= 1'b0;
          end else if (done_sync || dg_cnt_q >= DIAG_CNT - 32'h0000_0001) begin
            // RULE8 latch open/short result
            result_q   <= pdsr_cable_type'(res_sync);
            dg_state_q <= PDSR_DG_DONE;
            // RULE6 enable reads zero when done
            diag_en_q  <= 1'b0;
          end
        end
        PDSR_DG_DONE: begin
          dg_state_q <= PDSR_DG_IDLE;
        end
        default: begin
          dg_state_q <= PDSR_DG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cable_test_run_o <= 1'b0;
      cable_pair_o     <= 2'h0;
    end else begin
      cable_test_run_o <= (dg_state_q == PDSR_DG_RUN);
      cable_pair_o     <= pair_q;
    end
  end

  // RULE9 flag an errored frame, count at its end
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_err_q <= 1'b0;
    end else if (rx_frame_end_i) begin
      frame_err_q <= 1'b0;
    end else if (receive_symbol_error_i) begin
      frame_err_q <= 1'b1;
    end
  end

  logic frame_hit;
  assign frame_hit = rx_frame_end_i && (frame_err_q || receive_symbol_error_i);

  // RULE10 clear on read, count wins a tie, saturate
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      symerr_q <= 16'h0000;
    end else if (rd_acc && idx == `PDSR_IDX_SYMERR) begin
      symerr_q <= frame_hit ? 16'h0001 : 16'h0000;
    end else if (frame_hit && symerr_q != `PDSR_SYMERR_MAX) begin
      symerr_q <= symerr_q + 16'h0001;
    end
  end

  logic [`PDSR_IRQ_W-1:0] irq_ev;
  assign irq_ev = {(gig_sync != gig_prev_q) || (fast_sync != fast_prev_q),
                   frame_hit && symerr_q == 16'hFFFE,
                   dg_state_q == PDSR_DG_RUN && diag_en_q && (done_sync || dg_cnt_q >= DIAG_CNT - 32'h0000_0001)};

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gig_prev_q  <= 1'b0;
      fast_prev_q <= 1'b0;
    end else begin
      gig_prev_q  <= gig_sync;
      fast_prev_q <= fast_sync;
    end
  end

  // Sticky status: a new event wins over a write-one-to-clear
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_stat_q <= '0;
    end else if (wr_acc && idx == `PDSR_IDX_IRQ_STATUS && avs_byteenable_i[0]) begin
      irq_stat_q <= (irq_stat_q & ~avs_writedata_i[`PDSR_IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_q <= irq_stat_q | irq_ev;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_mask_q <= '0;
    end else if (wr_acc && idx == `PDSR_IDX_IRQ_MASK && avs_byteenable_i[0]) begin
      irq_mask_q <= avs_writedata_i[`PDSR_IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Assertions
  loop_line_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE2
    loop_q[`PDSR_LOOPBACK_BIT] |=> line_tx_data_o == $past(line_rx_data_i) && !fabric_rx_valid_o)
    else $error("line loopback path wrong");
  loop_mac_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE3
    loop_q[`PDSR_LOOPBACK_BIT] |=> mac_rxd_o == $past(mac_txd_i) && mac_rx_dv_o == $past(mac_tx_en_i))
    else $error("mac loopback path wrong");
  loop_normal_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE1
    !loop_q[`PDSR_LOOPBACK_BIT] |=> line_tx_data_o == $past(fabric_tx_data_i) && !mac_loopback_o)
    else $error("normal path wrong");
  diag_start_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE4
    dg_state_q == PDSR_DG_IDLE && wr_acc && idx == `PDSR_IDX_DIAG && wdiag[15] |=> diag_en_q ##1 cable_test_run_o)
    else $error("cable test did not start");
  diag_stop_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE5
    dg_state_q == PDSR_DG_RUN && wr_acc && idx == `PDSR_IDX_DIAG && !wdiag[15] |=>
      !diag_en_q && dg_state_q == PDSR_DG_IDLE)
    else $error("cable test did not stop");
  diag_busy_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE6
    diag_en_q == (dg_state_q == PDSR_DG_RUN))
    else $error("busy bit disagrees with test state");
  diag_pair_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE7
    wr_acc && idx == `PDSR_IDX_DIAG |=> ##1 cable_pair_o == $past(wdiag[13:12], 2))
    else $error("pair select not applied");
  diag_result_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE8
    dg_state_q == PDSR_DG_DONE |-> result_q == $past(res_sync))
    else $error("result not latched at completion");
  cnt_inc_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE9
    frame_hit && !(rd_acc && idx == `PDSR_IDX_SYMERR) && symerr_q != 16'hFFFF |=>
      symerr_q == $past(symerr_q) + 16'h0001)
    else $error("errored frame not counted");
  cnt_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // RULE10
    rd_acc && idx == `PDSR_IDX_SYMERR && !frame_hit |=> symerr_q == 16'h0000)
    else $error("counter not cleared by read");
endmodule
`default_nettype wire

// ---- pdsr_regs_test.sv ----
// Self-checking bench for the PHY diag/status register group.
// Assumes pdsr_regs with a short cable test limit; the bench drives every port itself.
`timescale 1ns/10ps
`default_nettype none
`include "pdsr_defines.svh"
module pdsr_regs_test;
  import pdsr_pkg::*;
  localparam int DCYC = 40;
  logic                    ref_clk_i = 1'b0;
  logic                    rstn_i = 1'b0;
  logic [`PDSR_ADDR_W-1:0] adr = '0;
  logic                    rd = 1'b0;
  logic                    wr = 1'b0;
  logic [31:0]             wdat = '0;
  logic [3:0]              be = 4'hF;
  wire  logic [31:0]       rdat;
  wire  logic              wait_req;
  wire  logic [1:0]        resp;
  logic [7:0]              lrx = '0, ftx = '0, mtx = '0, mfab = '0;
  logic                    lrx_v = 1'b0, ftx_v = 1'b0, mtx_en = 1'b0, mfab_v = 1'b0;
  wire  logic [7:0]        ltx, frx, mrxd;
  wire  logic              ltx_v, frx_v, mrx_dv, mloop, run, irq;
  wire  logic [1:0]        pair;
  logic                    sym_err = 1'b0, fend = 1'b0, cdone = 1'b0, lgig = 1'b0, lfast = 1'b0;
  logic [1:0]              cres = 2'h0;
  int                      fail_count = 0;
  int                      checks = 0;
  int                      cyc = 0;
  logic [31:0]             d;
  logic [1:0]              r;

  always #20 ref_clk_i = ~ref_clk_i;

  pdsr_regs #(.DIAG_CYCLES(DCYC)) dut (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req),
    .avs_response_o(resp),
    .line_rx_data_i(lrx), .line_rx_valid_i(lrx_v), .fabric_tx_data_i(ftx), .fabric_tx_valid_i(ftx_v),
    .line_tx_data_o(ltx), .line_tx_valid_o(ltx_v), .fabric_rx_data_o(frx), .fabric_rx_valid_o(frx_v),
    .mac_txd_i(mtx), .mac_tx_en_i(mtx_en), .mac_fabric_data_i(mfab), .mac_fabric_valid_i(mfab_v),
    .mac_rxd_o(mrxd), .mac_rx_dv_o(mrx_dv), .mac_loopback_o(mloop),
    .receive_symbol_error_i(sym_err), .rx_frame_end_i(fend),
    .cable_done_i(cdone), .cable_result_i(cres), .link_gig_i(lgig), .link_fast_i(lfast),
    .cable_test_run_o(run), .cable_pair_o(pair), .irq_o(irq)
  );

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Ceiling covers the long saturation run plus the short tests
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fail_count = fail_count + 1;
      $display("mismatch at %0t: run timed out", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks = checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Request is held until the edge where waitrequest is seen low
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] v, input logic [3:0] b);
    @(posedge ref_clk_i);
    adr <= {idx, 2'b00};
    wr <= w;
    rd <= ~w;
    wdat <= v;
    be <= b;
    // Only the global cycle ceiling ends a wait that never gets an answer
    do begin
      @(posedge ref_clk_i);
    end while (wait_req !== 1'b0);
    d = rdat;
    r = resp;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wr16(input logic [11:0] idx, input logic [15:0] v);
    bus(1'b1, idx, {16'h0000, v}, 4'hF);
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp, input string m);
    bus(1'b0, idx, 32'h0, 4'hF);
    chk(d, exp, m);
  endtask

  task automatic test_reset;
    rd_chk(`PDSR_IDX_LOOPBACK, 32'h0000_00F4, "loopback reset");
    chk({30'h0, r}, 32'h0, "mapped response");
    rd_chk(`PDSR_IDX_DIAG, 32'h0000_0000, "diag reset");
    rd_chk(`PDSR_IDX_SYMERR, 32'h0000_0000, "count reset");
    rd_chk(12'h3FF, 32'h0000_0000, "unmapped data");
    chk({30'h0, r}, 32'h2, "unmapped response");
    wr16(`PDSR_IDX_LOOPBACK, 16'hFEF4);
    rd_chk(`PDSR_IDX_LOOPBACK, 32'h0000_FEF4, "loopback reserved rw");
    wr16(`PDSR_IDX_LOOPBACK, 16'h00F7);
    rd_chk(`PDSR_IDX_LOOPBACK, 32'h0000_00F4, "loopback low bits read 0");
    $display("test reset done");
  endtask

  task automatic path(input logic lb);
    @(posedge ref_clk_i);
    lrx <= 8'h5A; ftx <= 8'hC3; mtx <= 8'h96; mfab <= 8'h3C;
    lrx_v <= 1'b1; ftx_v <= 1'b1; mtx_en <= 1'b1; mfab_v <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk(mloop, lb, "loopback flag");
    chk(ltx, lb ? 8'h5A : 8'hC3, "line transmit");
    chk(ltx_v, 1'b1, "line transmit valid");
    chk(frx_v, !lb, "fabric receive valid");
    chk(frx, lb ? 8'h00 : 8'h5A, "fabric receive");
    chk(mrxd, lb ? 8'h96 : 8'h3C, "mac receive");
    chk(mrx_dv, 1'b1, "mac receive valid");
  endtask

  task automatic test_loopback;
    path(1'b0);
    // Only the upper lane is enabled, lower byte must be kept
    bus(1'b1, `PDSR_IDX_LOOPBACK, 32'h0000_0100, 4'h2);
    rd_chk(`PDSR_IDX_LOOPBACK, 32'h0000_01F4, "loopback set");
    path(1'b1);
    wr16(`PDSR_IDX_LOOPBACK, 16'h00F4);
    path(1'b0);
    $display("test loopback done");
  endtask

  task automatic diag_poll;
    int n;
    n = 0;
    do begin
      bus(1'b0, `PDSR_IDX_DIAG, 32'h0, 4'hF);
      n++;
    end while (d[15] !== 1'b0 && n < 100);
  endtask

  task automatic test_diag;
    for (int p = 0; p < 4; p++) begin
      cres <= (p == 3) ? 2'h1 : p[1:0];
      wr16(`PDSR_IDX_DIAG, 16'h8000 | (p << 12));
      rd_chk(`PDSR_IDX_DIAG, 32'h8000 | (p << 12) | ((p == 0) ? 0 : ((p - 1) << 8)), "busy");
      chk(pair, p[1:0], "pair out");
      chk(run, 1'b1, "test running");
      cdone <= 1'b1;
      diag_poll();
      chk(d, 32'h0000_0000 | (p << 12) | (((p == 3) ? 1 : p) << 8), "result");
      cdone <= 1'b0;
      repeat (6) @(posedge ref_clk_i);
    end
    // No done from the tester: the test ends on its own limit
    cres <= 2'h2;
    wr16(`PDSR_IDX_DIAG, 16'h8000);
    diag_poll();
    chk(d, 32'h0000_0200, "limit end");
    $display("test diag done");
  endtask

  task automatic test_abort;
    cres <= 2'h1;
    wr16(`PDSR_IDX_DIAG, 16'hC000);
    wr16(`PDSR_IDX_DIAG, 16'h4000);
    rd_chk(`PDSR_IDX_DIAG, 32'h0000_4200, "abort keeps result");
    repeat (2) @(posedge ref_clk_i);
    chk(run, 1'b0, "stopped");
    $display("test abort done");
  endtask

  task automatic frame(input logic mid, input logic last);
    @(posedge ref_clk_i);
    sym_err <= mid;
    @(posedge ref_clk_i);
    sym_err <= last;
    fend <= 1'b1;
    @(posedge ref_clk_i);
    sym_err <= 1'b0;
    fend <= 1'b0;
  endtask

  task automatic test_count;
    frame(1'b1, 1'b0);
    frame(1'b0, 1'b0);
    frame(1'b0, 1'b1);
    rd_chk(`PDSR_IDX_SYMERR, 32'h0000_0002, "errored frames");
    rd_chk(`PDSR_IDX_SYMERR, 32'h0000_0000, "clear on read");
    @(posedge ref_clk_i);
    sym_err <= 1'b1;
    fend <= 1'b1;
    repeat (65540) @(posedge ref_clk_i);
    sym_err <= 1'b0;
    fend <= 1'b0;
    rd_chk(`PDSR_IDX_SYMERR, 32'h0000_FFFF, "saturate");
    rd_chk(`PDSR_IDX_IRQ_STATUS, 32'h0000_0006, "saturation event");
    rd_chk(`PDSR_IDX_SYMERR, 32'h0000_0000, "clear after saturate");
    $display("test count done");
  endtask

  task automatic test_irq;
    wr16(`PDSR_IDX_IRQ_STATUS, 16'h0007);
    wr16(`PDSR_IDX_IRQ_MASK, 16'h0001);
    cres <= 2'h0;
    wr16(`PDSR_IDX_DIAG, 16'h8000);
    diag_poll();
    repeat (2) @(posedge ref_clk_i);
    chk(irq, 1'b1, "irq on done");
    wr16(`PDSR_IDX_IRQ_STATUS, 16'h0001);
    repeat (2) @(posedge ref_clk_i);
    chk(irq, 1'b0, "irq cleared");
    wr16(`PDSR_IDX_IRQ_MASK, 16'h0000);
    lgig <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    rd_chk(`PDSR_IDX_LINK, 32'h0000_0002, "gig link");
    rd_chk(`PDSR_IDX_IRQ_STATUS, 32'h0000_0004, "link event");
    chk(irq, 1'b0, "masked irq");
    lfast <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    rd_chk(`PDSR_IDX_LINK, 32'h0000_0003, "both links");
    $display("test irq done");
  endtask

  initial begin
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    test_reset();
    test_loopback();
    test_diag();
    test_abort();
    test_irq();
    test_count();
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- pdsr_sync3.sv ----
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous input; output changes once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
`include "pdsr_defines.svh"
module pdsr_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rstn_i,
  // Data
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit: only take a level both later stages agree on
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_o <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          sync_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule
`default_nettype wire
